// ### rtl/adc_power_mode_sequencer.sv
// Power-mode sequencer: control capture, power state machine, track/hold
`timescale 1ns/1ps

// Overview of operation
// - Chip select falling when ready samples the input, starts conversion, puts track/hold in hold.
// - With write bit set, the first twelve serial bits load the control word.
// - A transfer with write bit zero leaves mode and power bits untouched.
// - A transfer is sixteen clocks; track resumes at the 14th falling edge.
// - Power bits one-zero: full shutdown, register kept, until bits change.
// - Wake write from full shutdown powers up at chip select rise, tracks at 14th.
// - Wake write needs a full frame; serial output stays undriven throughout it.
// - Power bits zero-one: power down at end of each conversion, hold while down.
// - Auto shutdown wakes at next chip select fall; track/hold returns to tracking.
// - Power-on mode is undefined until a dummy frame programs it.
// - For full shutdown: one dummy frame with bits one-zero, entered at rise.
// - Chip select rising early aborts, floats output, leaves control word unchanged.
// - Output word: two zeros, two channel bits, twelve result bits, MSB first.
module adc_power_mode_sequencer (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  input wire logic [adc_pm_pkg::RESULT_W-1:0] i_conv_result,
  output logic o_dout,
  output logic o_dout_oe_n,
  output logic o_hold,
  output logic o_conv_start,
  output logic o_powered,
  output logic o_ready,
  output logic [1:0] o_mode,
  output logic o_mode_known,
  output logic [adc_pm_pkg::CH_W-1:0] o_channel
);
  import adc_pm_pkg::*;

  pm_link_if lk ();

  logic [2:0] cs_sync_reg;
  logic cs_level_reg;
  logic [2:0] tg_sync_reg;
  logic tg_level_reg;
  logic frame_ok_reg;
  logic frame_ok_next;
  logic frame_valid_reg;
  logic frame_valid_next;
  pm_mode_t mode_reg;
  pm_mode_t mode_next;
  logic mode_known_reg;
  logic [CH_W-1:0] ch_reg;
  logic [CH_W-1:0] ch_next;
  pwr_state_t state_reg;
  pwr_state_t state_next;
  logic [WAKE_CNT_W-1:0] wake_cnt_reg;
  logic [WAKE_CNT_W-1:0] wake_cnt_next;
  logic conv_start_reg;

  pm_link_frame u_link (
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_resetn(i_resetn),
    .i_din(i_din),
    .o_dout(o_dout),
    .lk(lk)
  );

  // Result and channel are quiet during frames, so the link reads them directly
  assign lk.ch_id = ch_reg;
  assign lk.result = i_conv_result;

  // Synchroniser stage 0 feeds only stage 1; changes count once 1 and 2 agree
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_sync_reg <= 3'h7;
      cs_level_reg <= 1'b1;
      tg_sync_reg <= 3'h0;
      tg_level_reg <= 1'b0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], i_cs_n};
      tg_sync_reg <= {tg_sync_reg[1:0], lk.done_toggle};
      if (cs_sync_reg[1] == cs_sync_reg[2]) begin
        cs_level_reg <= cs_sync_reg[2];
      end
      if (tg_sync_reg[1] == tg_sync_reg[2]) begin
        tg_level_reg <= tg_sync_reg[2];
      end
    end
  end

  wire logic cs_stable = (cs_sync_reg[1] == cs_sync_reg[2]);
  wire logic cs_fall = cs_stable & ~cs_sync_reg[2] & cs_level_reg;
  wire logic cs_rise = cs_stable & cs_sync_reg[2] & ~cs_level_reg;
  wire logic tg_evt = (tg_sync_reg[1] == tg_sync_reg[2]) & (tg_sync_reg[2] != tg_level_reg);

  // Early chip select rise never produced a toggle, so nothing commits
  wire logic commit = cs_rise & (frame_ok_reg | tg_evt);
  wire logic pend_write = lk.ctrl_word[WRITE_BIT];
  wire pm_mode_t pend_pm = pm_mode_t'({lk.ctrl_word[PM_HI_BIT], lk.ctrl_word[PM_LO_BIT]});
  wire logic [CH_W-1:0] pend_ch = {lk.ctrl_word[CH_HI_BIT], lk.ctrl_word[CH_LO_BIT]};
  wire logic do_write = commit & pend_write;

  // Set wins over the clear at commit
  assign frame_ok_next = tg_evt | (frame_ok_reg & ~cs_rise);
  assign frame_valid_next = cs_fall ? (state_reg == PWR_ON) : frame_valid_reg;
  assign mode_next = do_write ? pend_pm : mode_reg;
  assign ch_next = do_write ? pend_ch : ch_reg;

  wire logic is_wake = (state_reg == PWR_WAKE);
  wire logic is_down = (state_reg == PWR_DOWN);
  wire logic auto_idle = (mode_reg == MODE_AUTO_SD) & (state_reg != PWR_ON);
  wire logic quiet = is_down & (mode_reg == MODE_FULL_SD);

  always_comb begin
    state_next = state_reg;
    wake_cnt_next = wake_cnt_reg;
    case (state_reg)
      PWR_ON: begin
        if (commit && mode_next == MODE_FULL_SD) begin
          state_next = PWR_DOWN;
        end else if (commit && mode_next == MODE_AUTO_SD && frame_valid_reg) begin
          state_next = PWR_DOWN;
        end
      end
      PWR_DOWN: begin
        if (commit && mode_next == MODE_NORMAL) begin
          state_next = PWR_WAKE;
          wake_cnt_next = POWER_UP_CYC;
        end else if (cs_fall && mode_reg == MODE_AUTO_SD) begin
          state_next = PWR_WAKE;
          wake_cnt_next = WAKE_AUTO_CYC;
        end
      end
      PWR_WAKE: begin
        if (commit && mode_next == MODE_FULL_SD) begin
          state_next = PWR_DOWN;
        end else if (wake_cnt_reg == WAKE_CNT_ONE) begin
          state_next = PWR_ON;
        end else begin
          wake_cnt_next = wake_cnt_reg - WAKE_CNT_ONE;
        end
      end
      default: begin
        state_next = PWR_DOWN;
      end
    endcase
  end

  // Mode after reset is a constant but flagged unknown until programmed
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      frame_ok_reg <= 1'b0;
      frame_valid_reg <= 1'b0;
      mode_reg <= RESET_MODE;
      mode_known_reg <= 1'b0;
      ch_reg <= RESET_CH;
      state_reg <= RESET_STATE;
      wake_cnt_reg <= 8'h00;
      conv_start_reg <= 1'b0;
    end else begin
      frame_ok_reg <= frame_ok_next;
      frame_valid_reg <= frame_valid_next;
      mode_reg <= mode_next;
      mode_known_reg <= mode_known_reg | do_write;
      ch_reg <= ch_next;
      state_reg <= state_next;
      wake_cnt_reg <= wake_cnt_next;
      conv_start_reg <= cs_fall & (state_reg == PWR_ON);
    end
  end

  // In a frame the edge count decides, forced low while auto shutdown is not ready; outside it shutdown holds
  assign o_hold = i_cs_n ? is_down : (lk.frame_hold & ~auto_idle);
  assign o_dout_oe_n = i_cs_n | lk.frame_done | quiet;
  assign o_conv_start = conv_start_reg;
  assign o_powered = ~is_down;
  assign o_ready = (state_reg == PWR_ON);
  assign o_mode = mode_reg;
  assign o_mode_known = mode_known_reg;
  assign o_channel = ch_reg;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  sequence auto_drop_s;
    cs_fall && is_down && (mode_reg == MODE_AUTO_SD) && !commit;
  endsequence

  sequence full_write_s;
    do_write && (pend_pm == MODE_FULL_SD);
  endsequence

  keep_mode_a: assert property (
    (commit && !pend_write) |=> $stable(mode_reg) && $stable(ch_reg)
  ) else $error("mode changed by a non-write frame");

  write_mode_a: assert property (
    do_write |=> (mode_reg == $past(pend_pm)) && o_mode_known
  ) else $error("written power bits not taken");

  mode_at_rise_a: assert property (
    (mode_reg != $past(mode_reg)) |-> $past(commit)
  ) else $error("mode changed away from a completed frame");

  full_down_a: assert property (
    full_write_s |=> is_down ##1 is_down
  ) else $error("full shutdown not entered at frame end");

  full_stay_a: assert property (
    (quiet && !commit) |=> quiet
  ) else $error("full shutdown left without a write");

  auto_down_a: assert property (
    (commit && (mode_next == MODE_AUTO_SD) && frame_valid_reg && o_ready)
      |=> is_down && o_hold
  ) else $error("auto shutdown did not power down after conversion");

  auto_wake_a: assert property (
    auto_drop_s |=> is_wake
  ) else $error("auto shutdown did not wake at chip select fall");

  wake_len_a: assert property (
    $rose(o_ready) |-> $past(is_wake, 1) && $past(is_wake, 125)
  ) else $error("ready raised before the wake time elapsed");

  quiet_out_a: assert property (
    quiet |-> o_dout_oe_n
  ) else $error("serial output driven in full shutdown");

  start_a: assert property (
    o_conv_start |-> $past(cs_fall) && $past(o_ready)
  ) else $error("conversion start without a powered chip select fall");

  start_pulse_a: assert property (
    (cs_fall && o_ready) |=> o_conv_start
  ) else $error("powered chip select fall gave no conversion start");

  start_once_a: assert property (
    o_conv_start |=> !o_conv_start
  ) else $error("conversion start longer than one cycle");

  abort_keep_a: assert property (
    (cs_rise && !frame_ok_reg && !tg_evt) |=> $stable(mode_reg) && $stable(ch_reg)
  ) else $error("cut frame changed the control word");

  known_stay_a: assert property (
    o_mode_known |=> o_mode_known
  ) else $error("programmed mode flag dropped");

  wake_load_a: assert property (
    (commit && is_down && (mode_next == MODE_NORMAL)) |=> is_wake && (wake_cnt_reg == POWER_UP_CYC)
  ) else $error("wake write did not start the power-up count");

  auto_load_a: assert property (
    auto_drop_s |=> (wake_cnt_reg == WAKE_AUTO_CYC)
  ) else $error("auto wake did not start its count");

  wake_hold_a: assert property (
    (is_wake && (wake_cnt_reg != WAKE_CNT_ONE) && !commit) |=> is_wake
  ) else $error("wake left before the count expired");

  channel_write_a: assert property (
    do_write |=> (o_channel == $past(pend_ch))
  ) else $error("written channel bits not taken");

  frame_set_a: assert property (
    (tg_evt && !cs_rise) |=> frame_ok_reg
  ) else $error("completed frame not remembered");

  frame_clear_a: assert property (
    (cs_rise && !tg_evt) |=> !frame_ok_reg
  ) else $error("completed frame flag not cleared at chip select rise");

  normal_stay_a: assert property (
    (o_ready && (mode_reg == MODE_NORMAL) && !do_write) |=> o_ready
  ) else $error("normal mode powered down without a write");

  // Reserved code is taken as a mode but must not move the power state
  reserved_a: assert property (
    (do_write && (pend_pm == MODE_RSVD) && !is_wake) |=> $stable(state_reg)
  ) else $error("reserved power code changed the power state");

endmodule : adc_power_mode_sequencer

// ### rtl/adc_pm_pkg.sv
// Shared constants and types for the converter power-mode sequencer
package adc_pm_pkg;

  // Serial frame layout
  localparam int CTRL_W = 12;
  localparam int RESULT_W = 12;
  localparam int CH_W = 2;
  localparam int DATA_SR_W = CH_W + RESULT_W;
  localparam int FRAME_CNT_W = 5;
  localparam logic [FRAME_CNT_W-1:0] EDGE_FIRST = 5'h00;
  localparam logic [FRAME_CNT_W-1:0] EDGE_CTRL_END = 5'h0C;
  localparam logic [FRAME_CNT_W-1:0] EDGE_HOLD_END = 5'h0E;
  localparam logic [FRAME_CNT_W-1:0] EDGE_LAST = 5'h0F;
  localparam logic [FRAME_CNT_W-1:0] EDGE_DONE = 5'h10;

  // Control word field positions
  localparam int WRITE_BIT = 11;
  localparam int CH_HI_BIT = 8;
  localparam int CH_LO_BIT = 7;
  localparam int PM_HI_BIT = 6;
  localparam int PM_LO_BIT = 5;

  typedef enum logic [1:0] {
    MODE_RSVD = 2'b00,
    MODE_AUTO_SD = 2'b01,
    MODE_FULL_SD = 2'b10,
    MODE_NORMAL = 2'b11
  } pm_mode_t;

  typedef enum logic [1:0] {
    PWR_ON = 2'b00,
    PWR_DOWN = 2'b01,
    PWR_WAKE = 2'b10
  } pwr_state_t;

  // Power-on mode is arbitrary in the part; these are just the flop constants
  localparam pm_mode_t RESET_MODE = MODE_FULL_SD;
  localparam pwr_state_t RESET_STATE = PWR_DOWN;
  localparam logic [CH_W-1:0] RESET_CH = 2'h0;

  // Timing
  localparam int SYS_CLK_MHZ = 125;
  localparam int NS_PER_US = 1000;
  localparam int T_POWER_UP_NS = 1000;
  localparam int T_WAKE_AUTO_NS = 1000;
  localparam int WAKE_CNT_W = 8;
  localparam int POWER_UP_CYC_I = (T_POWER_UP_NS * SYS_CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int WAKE_AUTO_CYC_I = (T_WAKE_AUTO_NS * SYS_CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam logic [WAKE_CNT_W-1:0] POWER_UP_CYC = WAKE_CNT_W'(POWER_UP_CYC_I);
  localparam logic [WAKE_CNT_W-1:0] WAKE_AUTO_CYC = WAKE_CNT_W'(WAKE_AUTO_CYC_I);
  localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_ONE = 8'h01;

endpackage : adc_pm_pkg

// ### rtl/pm_link_if.sv
// Signals between the serial-clock frame logic and the system-clock core
`timescale 1ns/1ps
interface pm_link_if;
  logic frame_hold;
  logic frame_done;
  logic done_toggle;
  logic [adc_pm_pkg::CTRL_W-1:0] ctrl_word;
  logic [adc_pm_pkg::CH_W-1:0] ch_id;
  logic [adc_pm_pkg::RESULT_W-1:0] result;

  modport link (
    output frame_hold, frame_done, done_toggle, ctrl_word,
    input ch_id, result
  );
  modport core (
    input frame_hold, frame_done, done_toggle, ctrl_word,
    output ch_id, result
  );
endinterface : pm_link_if

// ### rtl/pm_link_frame.sv
// Serial-clock frame logic: edge count, control capture, result shift-out
`timescale 1ns/1ps
module pm_link_frame (
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_resetn,
  input wire logic i_din,
  output logic o_dout,
  pm_link_if.link lk
);
  import adc_pm_pkg::*;

  logic [FRAME_CNT_W-1:0] edge_cnt_reg;
  logic [CTRL_W-1:0] ctrl_shift_reg;
  logic [CTRL_W-1:0] ctrl_word_reg;
  logic [DATA_SR_W-1:0] data_sr_reg;
  logic dout_reg;
  logic toggle_reg;

  wire logic first_edge = (edge_cnt_reg == EDGE_FIRST);
  wire logic last_edge = (edge_cnt_reg == EDGE_LAST);
  wire logic in_ctrl = (edge_cnt_reg < EDGE_CTRL_END);
  wire logic done = (edge_cnt_reg == EDGE_DONE);

  // Chip select high ends the frame even though the serial clock may stop
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      edge_cnt_reg <= EDGE_FIRST;
      dout_reg <= 1'b0;
      data_sr_reg <= 14'h0000;
    end else begin
      if (!done) begin
        edge_cnt_reg <= edge_cnt_reg + 5'h01;
      end
      if (first_edge) begin
        data_sr_reg <= {lk.ch_id, lk.result};
        dout_reg <= 1'b0;
      end else begin
        dout_reg <= data_sr_reg[DATA_SR_W-1];
        data_sr_reg <= {data_sr_reg[DATA_SR_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(negedge i_sclk) begin
    if (!i_cs_n && in_ctrl) begin
      ctrl_shift_reg <= {ctrl_shift_reg[CTRL_W-2:0], i_din};
    end
  end

  // Word is handed over only once the 16th edge is reached
  always_ff @(negedge i_sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_word_reg <= 12'h000;
      toggle_reg <= 1'b0;
    end else if (!i_cs_n && last_edge) begin
      ctrl_word_reg <= ctrl_shift_reg;
      toggle_reg <= ~toggle_reg;
    end
  end

  assign lk.frame_hold = ~i_cs_n & (edge_cnt_reg < EDGE_HOLD_END);
  assign lk.frame_done = done;
  assign lk.done_toggle = toggle_reg;
  assign lk.ctrl_word = ctrl_word_reg;
  assign o_dout = dout_reg;

  sequence frame_open_s;
    edge_cnt_reg == EDGE_FIRST;
  endsequence

  hold_release_a: assert property (
    @(negedge i_sclk) disable iff (i_cs_n)
    (edge_cnt_reg == EDGE_HOLD_END - 5'h01) |=> !lk.frame_hold
  ) else $error("hold not released at 14th falling edge");

  word_order_a: assert property (
    @(negedge i_sclk) disable iff (i_cs_n)
    frame_open_s |=> (o_dout == 1'b0) ##1 (o_dout == $past(lk.ch_id[1], 2))
  ) else $error("output word does not start 0 then channel bit");

  ctrl_capture_a: assert property (
    @(negedge i_sclk) disable iff (i_cs_n)
    last_edge |=> (lk.ctrl_word == $past(ctrl_shift_reg))
      && (lk.done_toggle != $past(lk.done_toggle))
  ) else $error("control word not handed over at last edge");

  full_frame_a: assert property (
    @(negedge i_sclk) disable iff (!i_resetn)
    (lk.done_toggle != $past(lk.done_toggle)) |-> ($past(edge_cnt_reg) == EDGE_LAST)
  ) else $error("frame handed over without sixteen edges");

endmodule : pm_link_frame

// ### dv/host_serial_model.sv
// Host serial-port model: frames chip select, serial clock and control word
`timescale 1ns/1ps
module host_serial_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din,
  input wire logic i_dout,
  input wire logic i_dout_oe_n,
  input wire logic i_hold
);
  logic [15:0] rx_word;
  logic [16:0] hold_seen;
  logic drove;
  realtime last_fall;
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_din = 1'b0;
    rx_word = 16'h0000;
    hold_seen = 17'h0_0000;
    drove = 1'b0;
    last_fall = -10000.0;
  end
  // Clock stands high outside frames; din toggles once no bit is owed
  task automatic frame(input logic [11:0] w, input int n);
    while ($realtime - last_fall < 5000.0) #1;
    drove = 1'b0;
    o_cs_n = 1'b0;
    last_fall = $realtime;
    #2 hold_seen[0] = i_hold;
    #18;
    for (int k = 1; k <= n; k++) begin
      o_din = (k <= 12) ? w[12-k] : ~o_din;
      #7.5;
      // A released line reads as the inverse, so a float is never taken as data
      rx_word[16-k] = (i_dout_oe_n === 1'b0) ? i_dout : ~i_dout;
      if (i_dout_oe_n === 1'b0) drove = 1'b1;
      o_sclk = 1'b0;
      #2 hold_seen[k] = i_hold;
      #5.5 o_sclk = 1'b1;
    end
    #10 o_cs_n = 1'b1;
    o_din = ~o_din;
    #100;
  endtask : frame
endmodule : host_serial_model

// ### dv/adc_power_mode_sequencer_tb.sv
// Self-checking bench for the converter power-mode sequencer
`timescale 1ns/1ps
module adc_power_mode_sequencer_tb;
  import adc_pm_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [RESULT_W-1:0] i_conv_result = 12'h000;
  logic sclk, cs_n, din, dout, dout_oe_n, hold, conv_start, powered, ready, mode_known;
  logic [1:0] mode;
  logic [CH_W-1:0] channel;
  int error_cnt = 0;
  int cmp_count = 0;
  int starts = 0;
  int s0;
  int n;
  always #4 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (conv_start === 1'b1) starts++;

  adc_power_mode_sequencer u_adc_power_mode_sequencer (.i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
    .i_conv_result(i_conv_result), .o_dout(dout), .o_dout_oe_n(dout_oe_n), .o_hold(hold),
    .o_conv_start(conv_start), .o_powered(powered), .o_ready(ready), .o_mode(mode),
    .o_mode_known(mode_known), .o_channel(channel));
  host_serial_model u_host_serial_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din),
    .i_dout(dout), .i_dout_oe_n(dout_oe_n), .i_hold(hold));

  function automatic logic [11:0] ctl(input logic wr, input logic [1:0] ch, input logic [1:0] pm);
    logic [11:0] w;
    w = 12'h000;
    w[WRITE_BIT] = wr;
    {w[CH_HI_BIT], w[CH_LO_BIT]} = ch;
    {w[PM_HI_BIT], w[PM_LO_BIT]} = pm;
    return w;
  endfunction : ctl

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // Commit lands well inside the host's quiet gap, so one edge later is settled
  task automatic xfer(input logic [11:0] w, input int edges);
    u_host_serial_model.frame(w, edges);
    @(negedge i_sys_clk);
  endtask : xfer

  task automatic wait_ready(output int cyc);
    for (cyc = 0; cyc < 300 && ready !== 1'b1; cyc++) @(negedge i_sys_clk);
  endtask : wait_ready

  initial begin
    #200000;
    error_cnt++;
    close_out();
  end

  initial begin
    repeat (12) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    check({mode, mode_known, powered, ready, dout_oe_n, hold}, {MODE_FULL_SD, 5'h03});
    repeat (4) @(negedge i_sys_clk);
    i_conv_result = 12'hA5C;
    xfer(ctl(1'b1, 2'h2, 2'h3), 16);
    check(u_host_serial_model.drove, 1'h0);
    check({mode, channel, mode_known}, {MODE_NORMAL, 3'h5});
    check(u_host_serial_model.hold_seen[14:13], 2'h1);
    check({powered, ready}, 2'h2);
    wait_ready(n);
    check(ready, 1'h1);
    check(n >= 90 && n <= 125, 1'h1);
    s0 = starts;
    xfer(ctl(1'b0, 2'h0, 2'h0), 16);
    check(u_host_serial_model.rx_word, 16'h2A5C);
    check({u_host_serial_model.drove, u_host_serial_model.hold_seen[0]}, 2'h3);
    check(starts - s0, 16'h0001);
    check(u_host_serial_model.hold_seen[14:13], 2'h1);
    check({mode, channel}, {MODE_NORMAL, 2'h2});
    xfer(ctl(1'b1, 2'h1, 2'h2), 10);
    check({mode, channel, dout_oe_n}, {MODE_NORMAL, 3'h5});
    xfer(ctl(1'b1, 2'h1, 2'h2), 16);
    check({mode, channel, powered}, {MODE_FULL_SD, 3'h2});
    s0 = starts;
    xfer(ctl(1'b0, 2'h0, 2'h0), 16);
    check({mode, powered, u_host_serial_model.drove}, {MODE_FULL_SD, 2'h0});
    check(starts - s0, 16'h0000);
    xfer(ctl(1'b1, 2'h1, 2'h1), 16);
    check({mode, powered, hold}, {MODE_AUTO_SD, 2'h1});
    xfer(ctl(1'b0, 2'h0, 2'h0), 16);
    check(u_host_serial_model.hold_seen[0], 1'h0);
    wait_ready(n);
    check({mode, ready}, {MODE_AUTO_SD, 1'h1});
    s0 = starts;
    xfer(ctl(1'b0, 2'h0, 2'h0), 16);
    check(starts - s0, 16'h0001);
    check({mode, powered, hold}, {MODE_AUTO_SD, 2'h1});
    xfer(ctl(1'b1, 2'h3, 2'h3), 16);
    check({mode, channel}, {MODE_NORMAL, 2'h3});
    close_out();
  end
endmodule : adc_power_mode_sequencer_tb
